// ---- hw/cpxd_pkg.sv ----
package cpxd_pkg;

  // ==========================================================
  // instruction field positions
  localparam int COND_HI        = 31;
  localparam int COND_LO        = 28;
  localparam int CLASS_HI       = 27;
  localparam int CLASS_LO       = 24;
  localparam int OPC_HI         = 23;
  localparam int OPC_LO         = 21;
  localparam int DIR_BIT        = 20;
  localparam int XREG_HI        = 19;
  localparam int XREG_LO        = 16;
  localparam int CORE_HI        = 15;
  localparam int CORE_LO        = 12;
  localparam int CPNUM_HI       = 11;
  localparam int CPNUM_LO       = 8;
  localparam int INFO_HI        = 7;
  localparam int INFO_LO        = 5;
  localparam int RT_MARK_BIT    = 4;
  localparam int OPND_HI        = 3;
  localparam int OPND_LO        = 0;
  localparam int LEN_BIT        = 22;
  localparam int UP_BIT         = 23;
  localparam int PRE_BIT        = 24;
  localparam int WB_BIT         = 21;
  localparam int OFS_HI         = 7;
  localparam int OFS_LO         = 0;
  localparam int LS_CLASS_HI    = 27;
  localparam int LS_CLASS_LO    = 25;

  // ==========================================================
  // encodings and constants
  localparam logic [3:0]  RT_CLASS    = 4'hE;
  localparam logic [2:0]  LS_CLASS    = 3'h6;
  localparam logic [3:0]  PC_REG      = 4'hF;
  localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0008;
  localparam int          FLAG_HI     = 31;
  localparam int          FLAG_LO     = 28;
  localparam logic [3:0]  FLAGS_RST   = 4'h0;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;

  typedef enum logic [3:0] {
    CND_EQ = 4'h0, CND_NE = 4'h1, CND_CS = 4'h2, CND_CC = 4'h3,
    CND_MI = 4'h4, CND_PL = 4'h5, CND_VS = 4'h6, CND_VC = 4'h7,
    CND_HI = 4'h8, CND_LS = 4'h9, CND_GE = 4'hA, CND_LT = 4'hB,
    CND_GT = 4'hC, CND_LE = 4'hD, CND_AL = 4'hE, CND_NV = 4'hF
  } cpxd_cond_type;

  typedef enum logic [1:0] {
    OP_NONE     = 2'b00,
    OP_TO_CP    = 2'b01,
    OP_FROM_CP  = 2'b10,
    OP_LOADSTORE = 2'b11
  } cpxd_op_type;

  // fields forwarded to the coprocessor
  typedef struct packed {
    logic [3:0] coproc_number;
    logic [2:0] coproc_operation_code;
    logic [3:0] coproc_xfer_reg;
    logic [3:0] coproc_operand_reg;
    logic [2:0] coproc_info_field;
    logic       to_core;
  } cpxd_cp_req_type;

  // load/store addressing fields
  typedef struct packed {
    logic        coproc_load;
    logic        long_xfer;
    logic        pre_index;
    logic        up;
    logic        write_back;
    logic [3:0]  base_reg;
    logic [3:0]  coproc_dest_reg;
    logic [31:0] byte_offset;
  } cpxd_ls_type;

endpackage

// ---- hw/cpxd_cond_eval.sv ----
`timescale 1ns/1ps
module cpxd_cond_eval
  import cpxd_pkg::*;
(
  input  wire logic [3:0] cond,
  input  wire logic [3:0] flags,
  output logic            pass
);
  logic n;
  logic z;
  logic c;
  logic v;

  // ==========================================================
  // condition table, flags ordered n z c v
  always_comb
  begin
    n = flags[3];
    z = flags[2];
    c = flags[1];
    v = flags[0];
    unique case (cpxd_cond_type'(cond))
      CND_EQ: pass = z;
      CND_NE: pass = !z;
      CND_CS: pass = c;
      CND_CC: pass = !c;
      CND_MI: pass = n;
      CND_PL: pass = !n;
      CND_VS: pass = v;
      CND_VC: pass = !v;
      CND_HI: pass = c && !z;
      CND_LS: pass = !c || z;
      CND_GE: pass = n == v;
      CND_LT: pass = n != v;
      CND_GT: pass = !z && (n == v);
      CND_LE: pass = z || (n != v);
      CND_AL: pass = 1'b1;
      CND_NV: pass = 1'b0;
    endcase
  end

endmodule // cpxd_cond_eval

// ---- hw/cpxd_decode.sv ----
`timescale 1ns/1ps
// Summary of operation
// RULE1 - transfer executes only when condition field bits 31:28 pass
// RULE2 - bit 20 zero sends core word out, one loads from coprocessor
// RULE3 - bits 3:0 forwarded as coprocessor operand register, uninterpreted
// RULE4 - bits 15:12 select the core register sending or receiving the word
// RULE5 - bits 19:16 forwarded as coprocessor transfer register number
// RULE6 - operation code field, lowest bit 21, forwarded unchanged
// RULE7 - bits 11:8 select exactly which coprocessor is addressed
// RULE8 - core never interprets opcode, coprocessor registers or info bits 7:5
// RULE9 - coprocessor conventionally reads opcode/info as operation selector
// RULE10 - load/store length bit is one for long, zero for short transfer
// RULE11 - load/store offset field counts words, scaled to bytes here
// RULE12 - toolchain lowers PC-based offset by 8 for read-ahead
// RULE13 - coproc load moves memory to coprocessor, store the reverse
// RULE14 - coprocessor-to-core transfer delivers a full 32-bit word
// RULE15 - coprocessor result may be moved into status condition flags
// RULE16 - destination PC: word bits 31:28 set n z c v, rest ignored
// RULE17 - coprocessor answers only when number field matches its own
// RULE18 - register transfer is 1110 in bits 27:24 with bit 4 set
module cpxd_decode
  import cpxd_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            instr_valid,
  input  wire logic [31:0]     instr,
  input  wire logic [3:0]      status_flags,
  input  wire logic [31:0]     core_reg_data,
  input  wire logic            cp_data_valid,
  input  wire logic [31:0]     cp_data,
  output logic                 cp_req_valid,
  output cpxd_cp_req_type      cp_req,
  output logic [31:0]          cp_wr_data,
  output logic                 ls_valid,
  output cpxd_ls_type          ls,
  output logic [3:0]           core_rd_sel,
  output logic                 core_wr_en,
  output logic [3:0]           core_wr_sel,
  output logic [31:0]          core_wr_data,
  output logic                 flags_wr_en,
  output logic [3:0]           flags_wr_data,
  output logic                 instr_skipped
);

  // ==========================================================
  // field access
  function automatic logic is_reg_xfer(input logic [31:0] w);
    // RULE18 class pattern
    return (w[CLASS_HI:CLASS_LO] == RT_CLASS) && w[RT_MARK_BIT];
  endfunction

  function automatic logic is_loadstore(input logic [31:0] w);
    return w[LS_CLASS_HI:LS_CLASS_LO] == LS_CLASS;
  endfunction

  function automatic logic is_pc_dest(input logic [3:0] r);
    // RULE16 program counter as destination
    return r == PC_REG;
  endfunction

  typedef enum logic {
    RET_IDLE = 1'b0,
    RET_WAIT = 1'b1
  } cpxd_ret_state_type;

  logic                  cond_pass;
  logic                  rt_hit;
  logic                  ls_hit;
  cpxd_op_type           op_kind;
  logic                  from_cp_issue;

  logic                  cp_req_valid_r;
  logic                  cp_req_valid_nxt;
  cpxd_cp_req_type       cp_req_r;
  cpxd_cp_req_type       cp_req_nxt;
  logic [31:0]           cp_wr_data_r;
  logic [31:0]           cp_wr_data_nxt;
  logic                  ls_valid_r;
  logic                  ls_valid_nxt;
  cpxd_ls_type           ls_r;
  cpxd_ls_type           ls_nxt;
  logic                  skip_r;
  logic                  skip_nxt;
  logic [3:0]            dest_r;
  logic [3:0]            dest_nxt;
  cpxd_ret_state_type    ret_state_r;
  cpxd_ret_state_type    ret_state_nxt;
  logic                  wr_en_r;
  logic                  wr_en_nxt;
  logic [31:0]           wr_data_r;
  logic [31:0]           wr_data_nxt;
  logic                  fl_en_r;
  logic                  fl_en_nxt;
  logic [3:0]            fl_data_r;
  logic [3:0]            fl_data_nxt;

  // ==========================================================
  // condition check
  // RULE1 condition gate
  cpxd_cond_eval u_cond
  (
    .cond  (instr[COND_HI:COND_LO]),
    .flags (status_flags),
    .pass  (cond_pass)
  );

  assign rt_hit      = instr_valid && is_reg_xfer(instr);
  assign ls_hit      = instr_valid && is_loadstore(instr);
  // RULE4 core register read select
  assign core_rd_sel = instr[CORE_HI:CORE_LO];

  // ==========================================================
  // instruction class
  always_comb
  begin
    op_kind = OP_NONE;
    if (cond_pass)
    begin
      if (rt_hit)
      begin
        // RULE2 direction picks transfer kind
        op_kind = instr[DIR_BIT] ? OP_FROM_CP : OP_TO_CP;
      end
      else if (ls_hit)
      begin
        // RULE13 memory transfer for coprocessor
        op_kind = OP_LOADSTORE;
      end
    end
  end

  assign from_cp_issue = (op_kind == OP_FROM_CP);

  // ==========================================================
  // issue stage
  always_comb
  begin
    cp_req_valid_nxt = 1'b0;
    cp_req_nxt       = cp_req_r;
    cp_wr_data_nxt   = cp_wr_data_r;
    ls_valid_nxt     = 1'b0;
    ls_nxt           = ls_r;
    // RULE1 failed condition
    skip_nxt         = (rt_hit || ls_hit) && !cond_pass;
    unique case (op_kind)
      OP_TO_CP, OP_FROM_CP:
      begin
        cp_req_valid_nxt = 1'b1;
        // RULE7 coprocessor select
        cp_req_nxt.coproc_number = instr[CPNUM_HI:CPNUM_LO];
        // RULE6 opcode forward
        cp_req_nxt.coproc_operation_code = instr[OPC_HI:OPC_LO];
        // RULE5 transfer register
        cp_req_nxt.coproc_xfer_reg = instr[XREG_HI:XREG_LO];
        // RULE3 operand register
        cp_req_nxt.coproc_operand_reg = instr[OPND_HI:OPND_LO];
        // RULE8 info passed raw
        cp_req_nxt.coproc_info_field = instr[INFO_HI:INFO_LO];
        // RULE2 direction bit
        cp_req_nxt.to_core = instr[DIR_BIT];
        cp_wr_data_nxt = instr[DIR_BIT] ? WORD_RST : core_reg_data;
      end
      OP_LOADSTORE:
      begin
        ls_valid_nxt = 1'b1;
        cp_req_valid_nxt = 1'b1;
        // RULE7 coprocessor select
        cp_req_nxt.coproc_number = instr[CPNUM_HI:CPNUM_LO];
        cp_req_nxt.coproc_operation_code = 3'h0;
        // RULE13 coprocessor register moved
        cp_req_nxt.coproc_xfer_reg = instr[CORE_HI:CORE_LO];
        cp_req_nxt.coproc_operand_reg = 4'h0;
        cp_req_nxt.coproc_info_field = 3'h0;
        cp_req_nxt.to_core = 1'b0;
        // RULE13 load versus store
        ls_nxt.coproc_load = instr[DIR_BIT];
        // RULE10 length bit
        ls_nxt.long_xfer = instr[LEN_BIT];
        ls_nxt.pre_index = instr[PRE_BIT];
        ls_nxt.up = instr[UP_BIT];
        ls_nxt.write_back = instr[WB_BIT];
        ls_nxt.base_reg = instr[XREG_HI:XREG_LO];
        ls_nxt.coproc_dest_reg = instr[CORE_HI:CORE_LO];
        // RULE11 word offset scaled
        ls_nxt.byte_offset = {22'h0, instr[OFS_HI:OFS_LO], 2'b00};
      end
      OP_NONE:
      begin
        // nothing goes to the coprocessor
        cp_req_valid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cp_req_valid_r <= 1'b0;
      cp_req_r       <= '0;
      cp_wr_data_r   <= WORD_RST;
      ls_valid_r     <= 1'b0;
      ls_r           <= '0;
      skip_r         <= 1'b0;
    end
    else
    begin
      cp_req_valid_r <= cp_req_valid_nxt;
      cp_req_r       <= cp_req_nxt;
      cp_wr_data_r   <= cp_wr_data_nxt;
      ls_valid_r     <= ls_valid_nxt;
      ls_r           <= ls_nxt;
      skip_r         <= skip_nxt;
    end
  end

  // ==========================================================
  // return path from coprocessor
  always_comb
  begin
    dest_nxt      = dest_r;
    ret_state_nxt = ret_state_r;
    wr_en_nxt     = 1'b0;
    wr_data_nxt   = wr_data_r;
    fl_en_nxt     = 1'b0;
    fl_data_nxt   = fl_data_r;
    if (from_cp_issue)
    begin
      // new request replaces a pending wait
      ret_state_nxt = RET_WAIT;
      dest_nxt      = instr[CORE_HI:CORE_LO];
    end
    else
    begin
      unique case (ret_state_r)
        RET_IDLE:
        begin
          // stray answer is dropped
          ret_state_nxt = RET_IDLE;
        end
        RET_WAIT:
        begin
          if (cp_data_valid)
          begin
            ret_state_nxt = RET_IDLE;
            if (is_pc_dest(dest_r))
            begin
              // RULE15 flags from coprocessor
              fl_en_nxt = 1'b1;
              // RULE16 top four bits only
              fl_data_nxt = cp_data[FLAG_HI:FLAG_LO];
            end
            else
            begin
              // RULE14 full word write
              wr_en_nxt   = 1'b1;
              wr_data_nxt = cp_data;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dest_r    <= 4'h0;
      ret_state_r <= RET_IDLE;
      wr_en_r   <= 1'b0;
      wr_data_r <= WORD_RST;
      fl_en_r   <= 1'b0;
      fl_data_r <= FLAGS_RST;
    end
    else
    begin
      dest_r    <= dest_nxt;
      ret_state_r <= ret_state_nxt;
      wr_en_r   <= wr_en_nxt;
      wr_data_r <= wr_data_nxt;
      fl_en_r   <= fl_en_nxt;
      fl_data_r <= fl_data_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign cp_req_valid  = cp_req_valid_r;
  assign cp_req        = cp_req_r;
  assign cp_wr_data    = cp_wr_data_r;
  assign ls_valid      = ls_valid_r;
  assign ls            = ls_r;
  assign instr_skipped = skip_r;
  assign core_wr_en    = wr_en_r;
  assign core_wr_sel   = dest_r;
  assign core_wr_data  = wr_data_r;
  assign flags_wr_en   = fl_en_r;
  assign flags_wr_data = fl_data_r;

endmodule // cpxd_decode

// ---- sim/cpxd_decode_chk.sv ----
`timescale 1ns/1ps
module cpxd_decode_chk
  import cpxd_pkg::*;
(
  input wire logic            core_clk,
  input wire logic            rst,
  input wire logic            instr_valid,
  input wire logic [31:0]     instr,
  input wire logic [31:0]     core_reg_data,
  input wire logic            cp_data_valid,
  input wire logic [31:0]     cp_data,
  input wire logic            cp_req_valid,
  input wire cpxd_cp_req_type cp_req,
  input wire logic [31:0]     cp_wr_data,
  input wire logic            ls_valid,
  input wire cpxd_ls_type     ls,
  input wire logic [3:0]      core_rd_sel,
  input wire logic            core_wr_en,
  input wire logic [31:0]     core_wr_data,
  input wire logic            flags_wr_en,
  input wire logic [3:0]      flags_wr_data,
  input wire logic            instr_skipped
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic        rt_in;
  logic        ls_in;
  logic        rt_r;
  logic [31:0] iw_r;
  assign rt_in = instr_valid && instr[27:24] == RT_CLASS && instr[4];
  assign ls_in = instr_valid && instr[27:25] == LS_CLASS;
  always_ff @(posedge core_clk)
  begin
    rt_r <= rt_in;
    iw_r <= instr;
  end
  // ==========================================================
  // assertions
  a_fields_fwd: assert property (
    cp_req_valid && rt_r |-> cp_req == {iw_r[11:8], iw_r[23:21], iw_r[19:16], iw_r[3:0], iw_r[7:5], iw_r[20]})
    else $error("forwarded fields wrong");
  a_issue_taken: assert property (rt_in && instr[31:28] == 4'hE |=> cp_req_valid && !instr_skipped)
    else $error("transfer not issued");
  a_other_quiet: assert property (
    instr_valid && !rt_in && !ls_in |=> !cp_req_valid && !ls_valid && !instr_skipped)
    else $error("other class produced output");
  a_never_cond: assert property (
    (rt_in || ls_in) && instr[31:28] == 4'hF |=> instr_skipped && !cp_req_valid && !ls_valid)
    else $error("failed condition not skipped");
  a_word_out: assert property (cp_req_valid && rt_r && !iw_r[20] |-> cp_wr_data == $past(core_reg_data))
    else $error("outgoing word wrong");
  a_rd_sel: assert property (core_rd_sel == instr[15:12])
    else $error("core read select wrong");
  a_ls_fields: assert property (
    ls_valid |-> ls == {iw_r[20], iw_r[22], iw_r[24], iw_r[23], iw_r[21], iw_r[19:12], 22'h0, iw_r[7:0], 2'h0})
    else $error("load store fields wrong");
  a_word_back: assert property (core_wr_en |-> $past(cp_data_valid) && core_wr_data == $past(cp_data))
    else $error("returned word wrong");
  a_flags_back: assert property (
    flags_wr_en |-> $past(cp_data_valid) && flags_wr_data == $past(cp_data[31:28]) && !core_wr_en)
    else $error("flag update wrong");
  c_word: cover property (core_wr_en);
  c_flags: cover property (flags_wr_en);
  c_ls: cover property (ls_valid && ls.long_xfer);
  c_skip: cover property (instr_skipped);
endmodule // cpxd_decode_chk

bind cpxd_decode cpxd_decode_chk u_chk
(
  .core_clk      (core_clk),
  .rst           (rst),
  .instr_valid   (instr_valid),
  .instr         (instr),
  .core_reg_data (core_reg_data),
  .cp_data_valid (cp_data_valid),
  .cp_data       (cp_data),
  .cp_req_valid  (cp_req_valid),
  .cp_req        (cp_req),
  .cp_wr_data    (cp_wr_data),
  .ls_valid      (ls_valid),
  .ls            (ls),
  .core_rd_sel   (core_rd_sel),
  .core_wr_en    (core_wr_en),
  .core_wr_data  (core_wr_data),
  .flags_wr_en   (flags_wr_en),
  .flags_wr_data (flags_wr_data),
  .instr_skipped (instr_skipped)
);

// ---- sim/cpxd_cp_model.sv ----
`timescale 1ns/1ps
module cpxd_cp_model
  import cpxd_pkg::*;
#(
  parameter logic [3:0] NUM = 4'h2
)
(
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            cp_req_valid,
  input  wire cpxd_cp_req_type cp_req,
  input  wire logic [3:0]      dly,
  output logic                 cp_data_valid,
  output logic [31:0]          cp_data
);
  logic [3:0]  cnt_r;
  logic [31:0] word_r;
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r         <= 4'h0;
      word_r        <= 32'h0;
      cp_data_valid <= 1'b0;
      cp_data       <= 32'h0;
    end
    else
    begin
      cp_data_valid <= 1'b0;
      cp_data <= ~cp_data;
      if (cp_req_valid && cp_req.to_core && cp_req.coproc_number == NUM)
      begin
        cnt_r <= dly;
        word_r <= {cp_req.coproc_xfer_reg, 4'h0, cp_req.coproc_operand_reg, 20'h5A5A5};
      end
      else if (cnt_r != 4'h0)
      begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1)
        begin
          cp_data_valid <= 1'b1;
          cp_data <= word_r;
        end
      end
    end
  end
endmodule // cpxd_cp_model

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  import cpxd_pkg::*;
  logic            core_clk, rst, instr_valid, cp_data_valid, cp_req_valid, ls_valid;
  logic            core_wr_en, flags_wr_en, instr_skipped;
  logic [31:0]     instr, core_reg_data, cp_data, cp_wr_data, core_wr_data;
  logic [3:0]      status_flags, core_rd_sel, core_wr_sel, flags_wr_data, dly;
  cpxd_cp_req_type cp_req;
  cpxd_ls_type     ls;
  int              n_errors = 0;
  int              tests_run = 0;
  int              cyc = 0;
  assign core_reg_data = {8{core_rd_sel}};
  cpxd_decode DUT
  (
    .core_clk      (core_clk),
    .rst           (rst),
    .instr_valid   (instr_valid),
    .instr         (instr),
    .status_flags  (status_flags),
    .core_reg_data (core_reg_data),
    .cp_data_valid (cp_data_valid),
    .cp_data       (cp_data),
    .cp_req_valid  (cp_req_valid),
    .cp_req        (cp_req),
    .cp_wr_data    (cp_wr_data),
    .ls_valid      (ls_valid),
    .ls            (ls),
    .core_rd_sel   (core_rd_sel),
    .core_wr_en    (core_wr_en),
    .core_wr_sel   (core_wr_sel),
    .core_wr_data  (core_wr_data),
    .flags_wr_en   (flags_wr_en),
    .flags_wr_data (flags_wr_data),
    .instr_skipped (instr_skipped)
  );
  cpxd_cp_model #(.NUM(4'h2)) u_cp (.core_clk(core_clk), .rst(rst), .cp_req_valid(cp_req_valid), .cp_req(cp_req),
    .dly(dly), .cp_data_valid(cp_data_valid), .cp_data(cp_data));
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ==========================================================
  // helpers
  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task issue(input logic [31:0] w);
    @(posedge core_clk);
    #1 instr_valid = 1'b1;
    instr = w;
    @(posedge core_clk);
    #1 instr_valid = 1'b0;
    instr = ~w;
  endtask
  task wait_ret(output logic got);
    got = 1'b0;
    repeat (20)
    begin
      @(posedge core_clk);
      #1;
      if (core_wr_en === 1'b1 || flags_wr_en === 1'b1)
      begin
        got = 1'b1;
        break;
      end
    end
  endtask
  // ==========================================================
  // scenarios
  task t_to_cp;
    issue(32'hEEA942DC);
    `CHK("req_valid", 1'b1, cp_req_valid)
    `CHK("cp_req", {4'h2, 3'h5, 4'h9, 4'hC, 3'h6, 1'b0}, cp_req)
    `CHK("cp_wr_data", 32'h44444444, cp_wr_data)
    $display("done t_to_cp");
  endtask
  task t_from_cp;
    logic got;
    dly = 4'h1;
    issue(32'hEE353256);
    `CHK("to_core", 1'b1, cp_req.to_core)
    wait_ret(got);
    `CHK("answer", 1'b1, got)
    `CHK("wr_sel", 4'h3, core_wr_sel)
    `CHK("wr_data", 32'h5065A5A5, core_wr_data)
    `CHK("flags_en", 1'b0, flags_wr_en)
    $display("done t_from_cp");
  endtask
  task t_flags;
    logic got;
    dly = 4'h6;
    issue(32'hEE35F256);
    wait_ret(got);
    `CHK("answer", 1'b1, got)
    `CHK("flags_en", 1'b1, flags_wr_en)
    `CHK("flags", 4'h5, flags_wr_data)
    `CHK("wr_en", 1'b0, core_wr_en)
    $display("done t_flags");
  endtask
  task t_cond;
    status_flags = 4'h0;
    issue(32'h0E353256);
    `CHK("eq fail", 2'b10, {instr_skipped, cp_req_valid})
    status_flags = 4'h4;
    issue(32'h0EA942DC);
    `CHK("eq pass", 2'b01, {instr_skipped, cp_req_valid})
    issue(32'hFEA942DC);
    `CHK("never", 2'b10, {instr_skipped, cp_req_valid})
    $display("done t_cond");
  endtask
  task t_ls;
    issue(32'hEDF53206);
    `CHK("ls_valid", 1'b1, ls_valid)
    `CHK("ls long", {5'h1F, 4'h5, 4'h3, 32'h18}, ls)
    `CHK("ls dest", 4'h3, cp_req.coproc_xfer_reg)
    issue({12'hED8, 4'hF, 8'h32, 8'((8'h28 - 8'h08) >> 2)});
    `CHK("ls short", {5'h06, 4'hF, 4'h3, 32'h20}, ls)
    $display("done t_ls");
  endtask
  task t_other;
    issue(32'hEE353246);
    `CHK("quiet", 3'b000, {cp_req_valid, ls_valid, instr_skipped})
    $display("done t_other");
  endtask
  task t_wrong_num;
    logic got;
    dly = 4'h1;
    issue(32'hEE353756);
    `CHK("number", 4'h7, cp_req.coproc_number)
    wait_ret(got);
    `CHK("no answer", 1'b0, got)
    $display("done t_wrong_num");
  endtask
  initial
  begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = 32'h0;
    status_flags = 4'h0;
    dly = 4'h1;
    repeat (12) @(posedge core_clk);
    #1 rst = 1'b0;
    t_to_cp();
    t_from_cp();
    t_flags();
    t_cond();
    t_ls();
    t_other();
    t_wrong_num();
    print_verdict();
  end
endmodule // tb
